// file: core/mqf_flags.sv
// Active-queue status flags for a multi-queue FIFO, with APB control
//
// What this block does
// [RULE1] Word-available flag falls one edge after write, two if margin missed; read raises at once.
// [RULE2] Packet mode, 36-to-36 only: same one/two edge assertion, read de-asserts at once.
// [RULE3] 36-bit input: almost-full after D+1-m writes if shared with 36 out, else D-m.
// [RULE4] 18-bit input almost-full after 2(D+1-m) writes shared, else 2(D-m); 9-bit input uses four.
// [RULE5] 36-bit input: full after D+1 writes when shared with 36 out, else D.
// [RULE6] 18-bit input full after 2(D+1) shared or 2D; 9-bit input uses four.
// [RULE7] Full flag falls on the very edge of the write that fills the queue.
// [RULE8] Full flag rises one edge after a freeing read, one more if margin missed.
// [RULE9] Almost-full offset resets to 8, or 128 with the select input high.
// [RULE10] Almost-full falls two edges after write; rises one after read, two if missed.
// [RULE11] Status bus bits fall two edges after write; rise one after read, two if missed.
// [RULE12] A write-port queue switch may delay a status bus change by one edge.
// [RULE13] Almost-empty rises after n+2 writes shared 36-to-36, n+1 for 18/9 output.
// [RULE14] Shared queue: almost-empty rises after 2(n+2) for 18 in, 4(n+2) for 9 in.
// [RULE15] Almost-empty offset resets to 128 with the select input high, else 8.
// [RULE16] After a write-port queue switch almost-full shows the new queue from edge two.
// [RULE17] Almost-empty falls two edges after read; rises one edge after a write, two if missed.
// [RULE18] All flags active low; every queue keeps its own boundary status.
`timescale 1ns/1ps
module mqf_flags #(
  parameter int NQ = 32,
  parameter int QDEPTH = 1024,
  parameter int FIFO_DEPTH = mqf_pkg::FIFO_DEPTH_DEF
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic default_offset_select_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Write port
  input wire logic wr_sel_en_i,
  input wire logic [4:0] wr_queue_i,
  input wire logic wr_en_i,
  output logic wr_ready_o,
  // Read port
  input wire logic rd_sel_en_i,
  input wire logic [4:0] rd_queue_i,
  input wire logic rd_en_i,
  // Flags, all active low
  output logic word_available_flag_n_o,
  output logic queue_full_flag_n_o,
  output logic almost_full_flag_n_o,
  output logic [7:0] almost_full_status_bus_n_o,
  output logic almost_empty_flag_n_o
);
  localparam int CW = $clog2(4 * (QDEPTH + 1) + 1);
  localparam int QW = 5;
  localparam int FLW = $clog2(FIFO_DEPTH) + 1;

  // Control and offset registers
  logic [31:0] ctrl_r;
  logic [mqf_pkg::OFS_W-1:0] af_ofs_r;
  logic [mqf_pkg::OFS_W-1:0] ae_ofs_r;
  mqf_pkg::mqf_mode_t mode;
  logic pkt_on;
  logic wr_miss;
  logic rd_miss;
  logic ov_miss;
  logic [1:0] ks;
  logic out36;

  // Port selections and switch pulses
  logic [QW-1:0] wsel_r;
  logic [QW-1:0] rsel_r;
  logic wsw_r;
  logic rsw_r;

  // Per-queue word counts and boundary status
  logic [CW-1:0] cnt_r [NQ];
  logic [CW-1:0] cnt_nxt [NQ];
  logic [NQ-1:0] full_now;
  logic [NQ-1:0] full_hit_nxt;
  logic [NQ-1:0] af_n_vec;
  logic [NQ-1:0] ae_n_vec;

  // Write buffer
  mqf_pkg::mqf_wreq_t push_req;
  mqf_pkg::mqf_wreq_t head_req;
  logic head_valid;
  logic drain_ready;
  logic drain_fire;
  logic [FLW-1:0] fifo_level;
  logic rd_fire;

  // Flag pipelines
  logic ov_r;
  logic ne_d_r;
  logic ff_r;
  logic ok_d_r;
  logic af_s1_r;
  logic af_r;
  logic [7:0] bus_s1_r;
  logic [7:0] bus_r;
  logic ae_s1_r;
  logic ae_r;

  // Decoded control fields
  assign mode = mqf_pkg::mqf_mode_t'(ctrl_r[mqf_pkg::CTRL_MODE_LSB +: 3]);
  assign pkt_on = ctrl_r[mqf_pkg::CTRL_PKT_BIT] & (mode == mqf_pkg::MQF_I36_O36); // [RULE2]
  assign wr_miss = ctrl_r[mqf_pkg::CTRL_WMISS_BIT];
  assign rd_miss = ctrl_r[mqf_pkg::CTRL_RMISS_BIT];
  assign ov_miss = pkt_on ? ctrl_r[mqf_pkg::CTRL_PMISS_BIT] : rd_miss; // [RULE2]

  // Narrow input ports count in halves or quarters of an output word
  always_comb begin
    ks = 2'd0;
    out36 = 1'b0;
    unique case (mode)
      mqf_pkg::MQF_I36_O36: begin
        out36 = 1'b1;
      end
      mqf_pkg::MQF_I18_O36: begin
        ks = 2'd1;
        out36 = 1'b1;
      end
      mqf_pkg::MQF_I9_O36: begin
        ks = 2'd2;
        out36 = 1'b1;
      end
      mqf_pkg::MQF_I36_O18, mqf_pkg::MQF_I36_O9: begin
        ks = 2'd0;
      end
      default: begin
        ks = 2'd0;
      end
    endcase
  end

  // Write requests are buffered; draining stalls on a full target queue
  assign push_req.queue = wsel_r;
  assign drain_ready = ~full_now[head_req.queue];
  assign drain_fire = head_valid & drain_ready;
  assign rd_fire = rd_en_i & (cnt_r[rsel_r] != '0);

  mqf_fifo #(
    .W($bits(mqf_pkg::mqf_wreq_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_wbuf (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(wr_en_i),
    .in_ready_o(wr_ready_o),
    .in_data_i(push_req),
    .out_valid_o(head_valid),
    .out_ready_i(drain_ready),
    .out_data_o(head_req),
    .level_o(fifo_level)
  );

  // Per-queue thresholds and counters, kept for every queue at all times
  for (genvar q = 0; q < NQ; q++) begin : g_q
    logic extra;
    logic [CW-1:0] base;
    logic [CW-1:0] full_thr;
    logic [CW-1:0] af_thr;
    logic [CW-1:0] ae_thr;
    logic inc;
    logic dec;
    // Extra word counts only while the read port also holds this queue
    assign extra = out36 & (rsel_r == QW'(q));
    assign base = CW'(QDEPTH) + CW'(extra);
    assign full_thr = base << ks; // [RULE5] [RULE6]
    assign af_thr = (base - CW'(af_ofs_r)) << ks; // [RULE3] [RULE4]
    assign ae_thr = (CW'(ae_ofs_r) + CW'(1) + CW'(extra)) << ks; // [RULE13] [RULE14]
    assign inc = drain_fire & (head_req.queue == QW'(q));
    assign dec = rd_fire & (rsel_r == QW'(q));
    assign cnt_nxt[q] = cnt_r[q] + CW'(inc) - CW'(dec);
    assign full_now[q] = (cnt_r[q] >= full_thr);
    assign full_hit_nxt[q] = (cnt_nxt[q] >= full_thr);
    assign af_n_vec[q] = (cnt_r[q] < af_thr); // [RULE18]
    assign ae_n_vec[q] = (cnt_r[q] >= ae_thr); // [RULE18]

    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        cnt_r[q] <= '0;
      end else begin
        cnt_r[q] <= cnt_nxt[q];
      end
    end
  end

  // Queue selection on both ports; a pulse marks the cycle after a switch
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wsel_r <= '0;
      rsel_r <= '0;
      wsw_r <= 1'b0;
      rsw_r <= 1'b0;
    end else begin
      wsw_r <= wr_sel_en_i & (wr_queue_i != wsel_r);
      rsw_r <= rd_sel_en_i & (rd_queue_i != rsel_r);
      if (wr_sel_en_i) begin
        wsel_r <= wr_queue_i;
      end
      if (rd_sel_en_i) begin
        rsel_r <= rd_queue_i;
      end
    end
  end

  // Word-available flag: a read that empties raises it on its own edge
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ov_r <= 1'b1;
      ne_d_r <= 1'b0;
    end else begin
      ne_d_r <= (cnt_r[rsel_r] != '0);
      if (cnt_nxt[rsel_r] == '0) begin
        ov_r <= 1'b1; // [RULE1] [RULE2]
      end else if (ov_miss) begin
        ov_r <= ~(ne_d_r & (cnt_r[rsel_r] != '0)); // [RULE1] [RULE2]
      end else begin
        ov_r <= ~(cnt_r[rsel_r] != '0); // [RULE1] [RULE2]
      end
    end
  end

  // Full flag: falls with the filling write, rises a cycle after freeing read, two if margin missed
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ff_r <= 1'b1;
      ok_d_r <= 1'b1;
    end else begin
      ok_d_r <= ~full_now[wsel_r];
      if (full_hit_nxt[wsel_r]) begin
        ff_r <= 1'b0; // [RULE7]
      end else if (wr_miss) begin
        ff_r <= ~full_now[wsel_r] & ok_d_r; // [RULE8]
      end else begin
        ff_r <= ~full_now[wsel_r]; // [RULE8]
      end
    end
  end

  // Almost-full flag: two-stage fall, fast rise unless margin missed
  // The fast path is blocked after a switch so the new queue shows at edge two
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      af_s1_r <= 1'b1;
      af_r <= 1'b1;
    end else begin
      af_s1_r <= af_n_vec[wsel_r]; // [RULE16]
      if (!wsw_r && !wr_miss && af_n_vec[wsel_r]) begin
        af_r <= 1'b1; // [RULE10]
      end else begin
        af_r <= af_s1_r; // [RULE10] [RULE16]
      end
    end
  end

  // Status bus for the first eight queues, single-flag timing except a one-edge hold after a write-port switch
  for (genvar b = 0; b < 8; b++) begin : g_bus
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        bus_s1_r[b] <= 1'b1;
        bus_r[b] <= 1'b1;
      end else begin
        bus_s1_r[b] <= af_n_vec[b];
        if (wsw_r) begin
          bus_r[b] <= bus_r[b]; // [RULE12]
        end else if (!wr_miss && af_n_vec[b]) begin
          bus_r[b] <= 1'b1; // [RULE11]
        end else begin
          bus_r[b] <= bus_s1_r[b]; // [RULE11]
        end
      end
    end
  end

  // Almost-empty flag on the read side, mirror of the almost-full timing
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ae_s1_r <= 1'b0;
      ae_r <= 1'b0;
    end else begin
      ae_s1_r <= ae_n_vec[rsel_r];
      if (!rsw_r && !rd_miss && ae_n_vec[rsel_r]) begin
        ae_r <= 1'b1; // [RULE17]
      end else begin
        ae_r <= ae_s1_r; // [RULE17]
      end
    end
  end

  assign word_available_flag_n_o = ov_r;
  assign queue_full_flag_n_o = ff_r;
  assign almost_full_flag_n_o = af_r;
  assign almost_full_status_bus_n_o = bus_r;
  assign almost_empty_flag_n_o = ae_r;

  // APB: zero wait states; unmapped addresses answer with an error
  logic apb_wr;
  logic apb_setup;
  logic addr_ok;
  assign pready_o = 1'b1;
  assign apb_wr = psel_i & penable_i & pwrite_i;
  assign apb_setup = psel_i & ~penable_i;
  assign addr_ok = (paddr_i == mqf_pkg::REG_CTRL) || (paddr_i == mqf_pkg::REG_OFFSET) ||
                   (paddr_i == mqf_pkg::REG_STATUS) || (paddr_i == mqf_pkg::REG_LEVEL);

  // Offsets take their defaults from the select input while reset is held
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_r <= mqf_pkg::CTRL_RESET;
      af_ofs_r <= default_offset_select_i ? mqf_pkg::OFS_DEF_HIGH : mqf_pkg::OFS_DEF_LOW; // [RULE9]
      ae_ofs_r <= default_offset_select_i ? mqf_pkg::OFS_DEF_HIGH : mqf_pkg::OFS_DEF_LOW; // [RULE15]
    end else if (apb_wr) begin
      if (paddr_i == mqf_pkg::REG_CTRL) begin
        ctrl_r <= {25'h0, pwdata_i[6:0]};
      end
      if (paddr_i == mqf_pkg::REG_OFFSET) begin
        af_ofs_r <= pwdata_i[mqf_pkg::OFS_AF_LSB +: mqf_pkg::OFS_W];
        ae_ofs_r <= pwdata_i[mqf_pkg::OFS_AE_LSB +: mqf_pkg::OFS_W];
      end
    end
  end

  // Read data is captured in the setup cycle so it is a flop in the access phase
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prdata_o <= '0;
      pslverr_o <= 1'b0;
    end else if (apb_setup) begin
      pslverr_o <= ~addr_ok;
      prdata_o <= '0;
      if (!pwrite_i) begin
        unique case (paddr_i)
          mqf_pkg::REG_CTRL: begin
            prdata_o <= ctrl_r;
          end
          mqf_pkg::REG_OFFSET: begin
            prdata_o <= {5'h0, ae_ofs_r, 5'h0, af_ofs_r};
          end
          mqf_pkg::REG_STATUS: begin
            prdata_o <= {11'h0, ov_r, ff_r, af_r, ae_r, ~wr_ready_o, 3'h0, wsel_r, 3'h0, rsel_r};
          end
          mqf_pkg::REG_LEVEL: begin
            prdata_o <= {(16 - FLW)'(0), fifo_level, (16 - CW)'(0), cnt_r[rsel_r]};
          end
          default: begin
            prdata_o <= '0;
          end
        endcase
      end
    end
  end

endmodule : mqf_flags

// file: core/mqf_pkg.sv
// Shared constants, modes and carrier types for the queue flag block
package mqf_pkg;

  // Register byte offsets on the APB port
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_OFFSET = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_LEVEL = 12'h00c;

  // Control register field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PKT_BIT = 3;
  localparam int CTRL_WMISS_BIT = 4;
  localparam int CTRL_RMISS_BIT = 5;
  localparam int CTRL_PMISS_BIT = 6;

  // Offset register field positions
  localparam int OFS_W = 11;
  localparam int OFS_AF_LSB = 0;
  localparam int OFS_AE_LSB = 16;

  // Offset defaults picked by the select input at reset
  localparam logic [OFS_W-1:0] OFS_DEF_LOW = 11'h008;
  localparam logic [OFS_W-1:0] OFS_DEF_HIGH = 11'h080;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int FIFO_DEPTH_DEF = 16;

  // Bus matching modes
  typedef enum logic [2:0] {
    MQF_I36_O36 = 3'b000,
    MQF_I36_O18 = 3'b001,
    MQF_I36_O9 = 3'b010,
    MQF_I18_O36 = 3'b011,
    MQF_I9_O36 = 3'b100
  } mqf_mode_t;

  // One buffered write request, tagged with its queue
  typedef struct packed {
    logic [4:0] queue;
  } mqf_wreq_t;

endpackage : mqf_pkg

// file: core/mqf_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module mqf_fifo #(
  parameter int W = 5,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_r[rp_r];
  assign level_o = cnt_r;

  // Storage array; no reset needed, contents are qualified by count
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : mqf_fifo

// file: verification/mqf_flags_props.sv
// Concurrent checks on the flag outputs of the queue flag block
`timescale 1ns/1ps
module mqf_flags_props (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic wr_sel_en_i,
  input wire logic rd_sel_en_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic word_available_flag_n_o,
  input wire logic queue_full_flag_n_o,
  input wire logic almost_full_flag_n_o,
  input wire logic [7:0] almost_full_status_bus_n_o,
  input wire logic almost_empty_flag_n_o
);
  logic [2:0] cfg_r;
  logic cfg;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // Selection or register traffic moves thresholds, so it excuses flag moves
  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      cfg_r <= 3'h7;
    else
      cfg_r <= {cfg_r[1:0], psel_i | wr_sel_en_i | rd_sel_en_i};
  end
  assign cfg = |cfg_r;
  // Full reached with no read and no traffic for two edges
  sequence s_full_set;
    $fell(queue_full_flag_n_o) && !cfg;
  endsequence
  sequence s_quiet;
    (!rd_en_i && !psel_i && !wr_sel_en_i && !rd_sel_en_i) [*2];
  endsequence
  a_reset_flags: assert property ($fell(rst_i) |-> word_available_flag_n_o &&
    queue_full_flag_n_o && almost_full_flag_n_o && almost_full_status_bus_n_o == 8'hff &&
    !almost_empty_flag_n_o) else $error("flags not idle after reset");
  a_ov_rise: assert property ($rose(word_available_flag_n_o) |-> $past(rd_en_i) || cfg)
    else $error("word flag rose without a read");
  a_ov_fall: assert property ($fell(word_available_flag_n_o) |->
    $past(wr_en_i, 3) || $past(wr_en_i, 4) || cfg) else $error("word flag fell off time");
  a_full_fall: assert property ($fell(queue_full_flag_n_o) |->
    $past(wr_en_i, 2) || $past(wr_en_i, 3) || cfg) else $error("full fell off time");
  a_full_rise: assert property ($rose(queue_full_flag_n_o) |->
    $past(rd_en_i, 2) || $past(rd_en_i, 3) || cfg) else $error("full rose off time");
  a_af_fall: assert property ($fell(almost_full_flag_n_o) |->
    $past(wr_en_i, 4) || $past(wr_en_i, 5) || cfg) else $error("almost full fell off time");
  a_full_then_af: assert property (s_full_set ##0 s_quiet |=> !almost_full_flag_n_o)
    else $error("almost full high two edges after full");
  a_ae_rise: assert property ($rose(almost_empty_flag_n_o) |->
    $past(wr_en_i, 3) || $past(wr_en_i, 4) || cfg) else $error("almost empty rose off time");
endmodule : mqf_flags_props

bind mqf_flags mqf_flags_props mqf_flags_props_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .wr_sel_en_i(wr_sel_en_i), .rd_sel_en_i(rd_sel_en_i), .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i), .word_available_flag_n_o(word_available_flag_n_o),
  .queue_full_flag_n_o(queue_full_flag_n_o), .almost_full_flag_n_o(almost_full_flag_n_o),
  .almost_full_status_bus_n_o(almost_full_status_bus_n_o),
  .almost_empty_flag_n_o(almost_empty_flag_n_o));

// file: verification/mqf_host.sv
// Host model that drives the queue write and read ports
`timescale 1ns/1ps
module mqf_host (
  input wire logic ref_clk_i,
  input wire logic wr_ready_i,
  output logic wr_sel_en_o,
  output logic [4:0] wr_queue_o,
  output logic wr_en_o,
  output logic rd_sel_en_o,
  output logic [4:0] rd_queue_o,
  output logic rd_en_o
);
  initial begin
    {wr_sel_en_o, wr_en_o, rd_sel_en_o, rd_en_o} = 4'h0;
    wr_queue_o = 5'h00;
    rd_queue_o = 5'h00;
  end
  // Select queues on both ports; released address lines carry junk
  task automatic sel(input logic [4:0] wq, input logic [4:0] rq);
    {wr_sel_en_o, rd_sel_en_o} <= 2'h3;
    wr_queue_o <= wq;
    rd_queue_o <= rq;
    @(posedge ref_clk_i);
    {wr_sel_en_o, rd_sel_en_o} <= 2'h0;
    wr_queue_o <= ~wq;
    rd_queue_o <= ~rq;
    repeat (5) @(posedge ref_clk_i);
  endtask : sel
  // One write held until taken, then idle so the flag pipes settle
  task automatic wr1();
    wr_en_o <= 1'b1;
    do @(posedge ref_clk_i); while (wr_ready_i !== 1'b1);
    wr_en_o <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
  endtask : wr1
  task automatic rd1();
    rd_en_o <= 1'b1;
    @(posedge ref_clk_i);
    rd_en_o <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
  endtask : rd1
endmodule : mqf_host

// file: verification/tb.sv
// Self-checking bench for the queue flag block
`timescale 1ns/1ps
module tb;
  localparam int D = 16;
  localparam int M = 8;
  logic clk, rst, dsel, psel, penable, pwrite, pready, pslverr, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic wsel, wen, wrdy, rsel, ren, ov_n, ff_n, af_n, ae_n;
  logic [4:0] wq, rq;
  logic [7:0] afb_n;
  int err_total, checked;
  mqf_flags #(.QDEPTH(D)) mqf_flags_i (.ref_clk_i(clk), .rst_i(rst),
    .default_offset_select_i(dsel), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .wr_sel_en_i(wsel), .wr_queue_i(wq), .wr_en_i(wen),
    .wr_ready_o(wrdy), .rd_sel_en_i(rsel), .rd_queue_i(rq), .rd_en_i(ren),
    .word_available_flag_n_o(ov_n), .queue_full_flag_n_o(ff_n), .almost_full_flag_n_o(af_n),
    .almost_full_status_bus_n_o(afb_n), .almost_empty_flag_n_o(ae_n));
  mqf_host mqf_host_i (.ref_clk_i(clk), .wr_ready_i(wrdy), .wr_sel_en_o(wsel),
    .wr_queue_o(wq), .wr_en_o(wen), .rd_sel_en_o(rsel), .rd_queue_o(rq), .rd_en_o(ren));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1
  // APB transfer held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let an edge pass so a following call never reassigns psel in this time step
    @(posedge clk);
  endtask : apb
  // Reset values, offset defaults and a refused address
  task automatic t_regs(input logic [10:0] ofs);
    apb(1'b0, mqf_pkg::REG_CTRL, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, mqf_pkg::REG_OFFSET, 32'h0);
    chk(rv, {5'h00, ofs, 5'h00, ofs});
    apb(1'b0, 12'h010, 32'h0);
    chk1(ev, 1'b1);
  endtask : t_regs
  // Fill one queue word by word, checking every flag after each write
  task automatic t_fill(input logic [2:0] md, input logic [4:0] q, input int k,
    input logic sh, input logic o36);
    int x;
    int lim;
    x = (sh && o36) ? 1 : 0;
    lim = k * (D + x);
    apb(1'b1, mqf_pkg::REG_CTRL, {29'h0, md});
    mqf_host_i.sel(q, sh ? q : 5'h1f);
    for (int i = 1; i <= lim; i++) begin
      mqf_host_i.wr1();
      chk1(ov_n, !sh);
      chk1(ff_n, i < lim);
      chk1(af_n, i < k * (D + x - M));
      chk1(afb_n[q[2:0]], i < k * (D + x - M));
      chk1(ae_n, sh && i >= k * (M + 1 + x));
    end
    if (md == 3'h0 && sh) begin
      mqf_host_i.rd1();
      chk1(ff_n, 1'b1);
    end
  endtask : t_fill
  // Packet mode with every margin-miss bit set; then the status word
  task automatic t_miss();
    apb(1'b1, mqf_pkg::REG_CTRL, 32'h0000_0078);
    mqf_host_i.sel(5'h07, 5'h07);
    mqf_host_i.wr1();
    chk1(ov_n, 1'b0);
    chk1(ae_n, 1'b0);
    mqf_host_i.rd1();
    chk1(ov_n, 1'b1);
    chk1(wrdy, 1'b1);
    apb(1'b0, mqf_pkg::REG_STATUS, 32'h0);
    chk(rv, 32'h001c_0707);
  endtask : t_miss
  // Emptying read, then a return to a queue filled earlier
  task automatic t_drain();
    apb(1'b1, mqf_pkg::REG_CTRL, 32'h0);
    mqf_host_i.sel(5'h06, 5'h06);
    mqf_host_i.wr1();
    chk1(ov_n, 1'b0);
    mqf_host_i.rd1();
    chk1(ov_n, 1'b1);
    mqf_host_i.sel(5'h00, 5'h00);
    chk1(ff_n, 1'b1);
    chk1(af_n, 1'b0);
    chk1(afb_n[0], 1'b0);
    chk1(ae_n, 1'b1);
  endtask : t_drain
  task automatic stop_test();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    stop_test();
  end
  initial begin
    {rst, dsel, psel, penable, pwrite} = 5'h10;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_total = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs(11'h008);
    t_fill(mqf_pkg::MQF_I36_O36, 5'h00, 1, 1'b1, 1'b1);
    t_fill(mqf_pkg::MQF_I36_O36, 5'h01, 1, 1'b0, 1'b1);
    t_fill(mqf_pkg::MQF_I36_O9, 5'h02, 1, 1'b1, 1'b0);
    t_fill(mqf_pkg::MQF_I18_O36, 5'h03, 2, 1'b1, 1'b1);
    t_fill(mqf_pkg::MQF_I9_O36, 5'h04, 4, 1'b1, 1'b1);
    t_fill(mqf_pkg::MQF_I36_O18, 5'h05, 1, 1'b1, 1'b0);
    t_drain();
    t_miss();
    // Second reset with the high offset defaults
    rst <= 1'b1;
    dsel <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs(11'h080);
    stop_test();
  end
endmodule : tb
